// ### design/bspsa_cfg.svh
`ifndef BSPSA_CFG_SVH
`define BSPSA_CFG_SVH
// word and lane geometry
`define BSPSA_WORD_W 18
`define BSPSA_LANES 2
`define BSPSA_LANE_W 9
`define BSPSA_BURST 4
// burst-level address: four arrays of 256K words each
`define BSPSA_ADDR_W 18
// edges (sys_clk cycles) counted from the K rise that starts an access
`define BSPSA_RD_SNAP 4
`define BSPSA_RD_FIRST 5
`define BSPSA_WR_FIRST 2
`define BSPSA_WR_COMMIT 6
// length of the start history kept for each port
`define BSPSA_HIST 9
// entries of the read return buffer in the controller
`define BSPSA_BUF_DEPTH 2
`endif

// ### design/bspsa_pkg.sv
`include "bspsa_cfg.svh"
package bspsa_pkg;
	// kind of access started at a positive clock rise
	typedef enum {OP_NONE, OP_READ, OP_WRITE} bspsa_op_t;
	// one data word on either data path
	typedef logic [`BSPSA_WORD_W-1:0] bspsa_word_t;
endpackage

// ### design/bspsa_link_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "bspsa_cfg.svh"
interface bspsa_link_if #(
	parameter int ADDR_W = `BSPSA_ADDR_W
);
	// phase marker: high before an edge that is a positive clock rise
	logic kClk;
	// shared address for both ports
	logic [ADDR_W-1:0] addr;
	// port selects, active low
	logic readPortSelectN;
	logic writePortSelectN;
	// write data and per-lane write enables, active low
	bspsa_pkg::bspsa_word_t wrData;
	logic [`BSPSA_LANES-1:0] laneWriteEnN;
	// read data and its output enable (high while driven)
	bspsa_pkg::bspsa_word_t rdData;
	logic rdOe;
	modport dev(
		input kClk, addr, readPortSelectN, writePortSelectN, wrData, laneWriteEnN,
		output rdData, rdOe
	);
	modport host(
		output kClk, addr, readPortSelectN, writePortSelectN, wrData, laneWriteEnN,
		input rdData, rdOe
	);
endinterface
`default_nettype wire

// ### design/bspsa_sram_dev.sv
`timescale 1ns/10ps
`default_nettype none
`include "bspsa_cfg.svh"
module bspsa_sram_dev #(
	parameter int ADDR_W = `BSPSA_ADDR_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	bspsa_link_if.dev link,
	output logic readActive,
	output logic writeActive
);
	localparam int WW = `BSPSA_WORD_W;
	localparam int NL = `BSPSA_LANES;
	localparam int LW = `BSPSA_LANE_W;
	localparam int BL = `BSPSA_BURST;
	localparam int HN = `BSPSA_HIST;
	localparam int RD_SNAP = `BSPSA_RD_SNAP;
	localparam int RD_FIRST = `BSPSA_RD_FIRST;
	localparam int WR_FIRST = `BSPSA_WR_FIRST;
	localparam int WR_COMMIT = `BSPSA_WR_COMMIT;
	localparam int DEPTH = 1 << ADDR_W;

	// each sys_clk edge is one clock rise; kClk tells which of the two
	logic kRise;
	// start history: bit n set means a start n+1 edges ago
	logic [HN-1:0] rdHist;
	logic [HN-1:0] wrHist;
	// starts decided at this edge
	logic startRead;
	logic startWrite;
	// latched read address
	logic [ADDR_W-1:0] rdAddr;
	// latched write address, then the address of the collected burst
	logic [ADDR_W-1:0] wrAddr;
	logic [ADDR_W-1:0] wrBufAddr;
	// collected write burst and its lane enables, active high
	logic [WW-1:0] wrBuf [BL];
	logic [NL-1:0] wrBe [BL];
	// the collected burst goes to the array at this edge
	logic commitNow;
	// fetched read burst waiting for launch
	logic [WW-1:0] rdBurst [BL];
	// array word with any same-edge commit folded in
	logic [WW-1:0] fwdWord [BL];
	// storage arrays, one per burst word position
	logic [WW-1:0] mem [BL][DEPTH];

	// replace only the enabled lanes of a stored word
	function automatic logic [WW-1:0] laneMerge(
		input logic [WW-1:0] oldW,
		input logic [WW-1:0] newW,
		input logic [NL-1:0] en
	);
		logic [WW-1:0] res;
		res = oldW;
		for (int l = 0; l < NL; l++) begin
			if (en[l]) begin
				res[l*LW +: LW] = newW[l*LW +: LW];
			end
		end
		return res;
	endfunction

	// phase comes straight from controller logic on this clock
	// starts only at positive rises
	assign kRise = link.kClk;

	// arbitration of the two selects at a positive rise
	always_comb begin
		// previous rise read, so no read now
		// read wins from idle or after a write
		startRead = kRise && !link.readPortSelectN && !rdHist[1];
		// previous rise write, so no write now
		// one address, so only one start per rise
		startWrite = kRise && !link.writePortSelectN && !wrHist[1] && !startRead;
	end

	// start histories, one per port
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdHist <= '0;
			wrHist <= '0;
		end else begin
			rdHist <= {rdHist[HN-2:0], startRead};
			wrHist <= {wrHist[HN-2:0], startWrite};
		end
	end

	// address capture for each port at its own start
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdAddr <= '0;
			wrAddr <= '0;
		end else begin
			if (startRead) begin
				rdAddr <= link.addr;
			end
			if (startWrite) begin
				wrAddr <= link.addr;
			end
		end
	end

	// write data input registers, one slot per burst word
	// a new write may overwrite wrAddr before this burst commits,
	// so the address moves with the first word
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrBufAddr <= '0;
			for (int k = 0; k < BL; k++) begin
				wrBuf[k] <= '0;
				wrBe[k] <= '0;
			end
		end else begin
			if (wrHist[WR_FIRST-1]) begin
				wrBufAddr <= wrAddr;
			end
			for (int k = 0; k < BL; k++) begin
				// lowest word at next positive rise
				// only bursts already started are taken
				// lane enables registered with each word
				if (wrHist[WR_FIRST-1+k]) begin
					// data only from the write inputs
					wrBuf[k] <= link.wrData;
					wrBe[k] <= ~link.laneWriteEnN;
				end
			end
		end
	end

	// whole burst collected, write it now
	assign commitNow = wrHist[WR_COMMIT-1];

	// array write, one word per array at one address
	// storage carries no reset; its contents are undefined at power-up
	always_ff @(posedge sys_clk) begin
		if (commitNow) begin
			for (int k = 0; k < BL; k++) begin
				// word k goes to array k
				// disabled lanes keep the old byte
				mem[k][wrBufAddr] <= laneMerge(mem[k][wrBufAddr], wrBuf[k], wrBe[k]);
			end
		end
	end

	// array fetch for the read, with forwarding
	always_comb begin
		for (int k = 0; k < BL; k++) begin
			fwdWord[k] = mem[k][rdAddr];
			// a commit in the fetch edge is seen at once
			if (commitNow && (wrBufAddr == rdAddr)) begin
				fwdWord[k] = laneMerge(mem[k][rdAddr], wrBuf[k], wrBe[k]);
			end
		end
	end

	// fetch register, loaded one edge before the first launch
	// fetching late keeps reads coherent with writes begun earlier
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int k = 0; k < BL; k++) begin
				rdBurst[k] <= '0;
			end
		end else if (rdHist[RD_SNAP-1]) begin
			for (int k = 0; k < BL; k++) begin
				// position k holds address word k
				rdBurst[k] <= fwdWord[k];
			end
		end
	end

	// output registers: data and enable launched together
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			link.rdData <= '0;
			link.rdOe <= 1'b0;
		end else begin
			// default: nothing scheduled, output floats
			// off at the edge after the last word
			link.rdData <= '0;
			link.rdOe <= 1'b0;
			for (int k = 0; k < BL; k++) begin
				// first word at the third negative rise
				if (rdHist[RD_FIRST-1+k]) begin
					link.rdData <= rdBurst[k];
					link.rdOe <= 1'b1;
				end
			end
		end
	end

	// status levels for the user side
	assign readActive = |rdHist[RD_FIRST+BL-2:0];
	assign writeActive = |wrHist[WR_COMMIT-1:0];
endmodule
`default_nettype wire

// ### design/bspsa_host_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "bspsa_cfg.svh"
module bspsa_host_ctrl #(
	parameter int ADDR_W = `BSPSA_ADDR_W,
	parameter int BUF_DEPTH = `BSPSA_BUF_DEPTH
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	bspsa_link_if.host link,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic cmdWrite,
	input wire logic [ADDR_W-1:0] cmdAddr,
	input wire logic [`BSPSA_WORD_W*`BSPSA_BURST-1:0] cmdData,
	input wire logic [`BSPSA_LANES*`BSPSA_BURST-1:0] cmdLaneEn,
	output logic rspValid,
	input wire logic rspReady,
	output logic [`BSPSA_WORD_W*`BSPSA_BURST-1:0] rspData
);
	localparam int WW = `BSPSA_WORD_W;
	localparam int NL = `BSPSA_LANES;
	localparam int BL = `BSPSA_BURST;
	localparam int BW = WW * BL;
	localparam int EW = NL * BL;
	localparam int CW = $clog2(BUF_DEPTH + 1);
	localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

	// kind started at the previous positive rise
	bspsa_pkg::bspsa_op_t lastKind;
	// next edge is a negative rise; the selects it sets meet the positive rise after it
	logic issueSlot;
	logic issue;
	// reads still to return, and room for their bursts
	logic [CW-1:0] inFlight;
	logic roomForRead;
	// write burst: held one edge, then shifted out word by word
	logic wrPend;
	logic [BW-1:0] wrHold;
	logic [EW-1:0] wrHoldEn;
	logic [BW-1:0] wrShift;
	logic [EW-1:0] wrShiftEn;
	logic [2:0] wrCnt;
	// read assembly
	logic [BW-1:0] rdAsm;
	logic [1:0] rdCnt;
	logic push;
	// return buffer
	logic [BW-1:0] bufMem [BUF_DEPTH];
	logic [PW-1:0] wrPtr;
	logic [PW-1:0] rdPtr;
	logic [CW-1:0] bufCount;
	logic pop;

	assign issueSlot = !link.kClk;
	// a read is taken only while its whole burst fits in the buffer
	assign roomForRead = ({1'b0, bufCount} + {1'b0, inFlight}) < (CW+1)'(BUF_DEPTH);
	// no read at the rise after a read
	// no write at the rise after a write
	assign cmdReady = issueSlot && (cmdWrite ? (lastKind != bspsa_pkg::OP_WRITE)
		: ((lastKind != bspsa_pkg::OP_READ) && roomForRead));
	assign issue = cmdValid && cmdReady;
	assign push = link.rdOe && (rdCnt == 2'(BL - 1));
	assign pop = rspValid && rspReady;

	// clock divider, selects and address
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			link.kClk <= 1'b0;
			link.addr <= '0;
			link.readPortSelectN <= 1'b1;
			link.writePortSelectN <= 1'b1;
			lastKind <= bspsa_pkg::OP_NONE;
		end else begin
			link.kClk <= !link.kClk;
			// selects stand for one edge only, the positive rise
			link.readPortSelectN <= !(issue && !cmdWrite);
			link.writePortSelectN <= !(issue && cmdWrite);
			if (issue) begin
				link.addr <= cmdAddr;
			end
			if (issueSlot) begin
				case ({issue, cmdWrite})
					2'b10: lastKind <= bspsa_pkg::OP_READ;
					2'b11: lastKind <= bspsa_pkg::OP_WRITE;
					default: lastKind <= bspsa_pkg::OP_NONE;
				endcase
			end
		end
	end

	// write data: word 0 on the link two edges after the start rise
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPend <= 1'b0;
			wrHold <= '0;
			wrHoldEn <= '0;
			wrShift <= '0;
			wrShiftEn <= '0;
			wrCnt <= '0;
			link.wrData <= '0;
			link.laneWriteEnN <= '1;
		end else begin
			wrPend <= issue && cmdWrite;
			if (issue && cmdWrite) begin
				wrHold <= cmdData;
				wrHoldEn <= cmdLaneEn;
			end
			if (wrCnt != 3'h0) begin
				link.wrData <= wrShift[WW-1:0];
				link.laneWriteEnN <= ~wrShiftEn[NL-1:0];
			end else begin
				link.wrData <= '0;
				link.laneWriteEnN <= '1;
			end
			// reload lands on the last word of a back-to-back burst
			if (wrPend) begin
				wrShift <= wrHold;
				wrShiftEn <= wrHoldEn;
				wrCnt <= 3'(BL);
			end else if (wrCnt != 3'h0) begin
				wrShift <= {{WW{1'b0}}, wrShift[BW-1:WW]};
				wrShiftEn <= {{NL{1'b0}}, wrShiftEn[EW-1:NL]};
				wrCnt <= wrCnt - 3'h1;
			end
		end
	end

	// read assembly and in-flight count
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdAsm <= '0;
			rdCnt <= '0;
			inFlight <= '0;
		end else begin
			if (link.rdOe) begin
				rdAsm <= {link.rdData, rdAsm[BW-1:WW]};
				rdCnt <= rdCnt + 2'h1;
			end
			case ({issue && !cmdWrite, push})
				2'b10: inFlight <= inFlight + CW'(1);
				2'b01: inFlight <= inFlight - CW'(1);
				default: inFlight <= inFlight;
			endcase
		end
	end

	// return buffer; push never meets a full buffer by the read budget
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			bufCount <= '0;
			for (int i = 0; i < BUF_DEPTH; i++) begin
				bufMem[i] <= '0;
			end
		end else begin
			if (push) begin
				bufMem[wrPtr] <= {link.rdData, rdAsm[BW-1:WW]};
				wrPtr <= (wrPtr == PW'(BUF_DEPTH - 1)) ? '0 : wrPtr + PW'(1);
			end
			if (pop) begin
				rdPtr <= (rdPtr == PW'(BUF_DEPTH - 1)) ? '0 : rdPtr + PW'(1);
			end
			case ({push, pop})
				2'b10: bufCount <= bufCount + CW'(1);
				2'b01: bufCount <= bufCount - CW'(1);
				default: bufCount <= bufCount;
			endcase
		end
	end

	assign rspValid = (bufCount != '0);
	assign rspData = bufMem[rdPtr];
endmodule
`default_nettype wire

// ### tb/bspsa_link_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "bspsa_cfg.svh"
// watches the link between the two ends
module bspsa_link_checker #(
	parameter int ADDR_W = `BSPSA_ADDR_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic kClk,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic readPortSelectN,
	input wire logic writePortSelectN,
	input wire bspsa_pkg::bspsa_word_t wrData,
	input wire logic [`BSPSA_LANES-1:0] laneWriteEnN,
	input wire bspsa_pkg::bspsa_word_t rdData,
	input wire logic rdOe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// a start is a low select seen at a positive clock rise
	wire logic readStart = kClk && !readPortSelectN;
	wire logic writeStart = kClk && !writePortSelectN;
	// four words of one burst, sampled from six edges on
	sequence burstOut;
		##6 rdOe [*4];
	endsequence
	// a read with no follow-on read four edges later
	sequence loneRead;
		readStart ##4 !readStart;
	endsequence
	a_read_burst_out: assert property (readStart |-> burstOut)
		else $error("read burst missing on outputs");
	a_read_float_after: assert property (loneRead |-> ##6 !rdOe)
		else $error("outputs still driven after burst");
	a_read_chain: assert property (readStart ##4 readStart |-> ##2 rdOe [*8])
		else $error("gap between paired read bursts");
	a_idle_zero: assert property (!rdOe |-> rdData == '0)
		else $error("read data moves while undriven");
	a_start_on_k: assert property ((!readPortSelectN || !writePortSelectN) |-> kClk)
		else $error("select low off a positive rise");
	a_read_spacing: assert property (readStart |=> readPortSelectN [*3])
		else $error("reads issued too close");
	a_write_spacing: assert property (writeStart |=> writePortSelectN [*3])
		else $error("writes issued too close");
	a_lane_window: assert property (laneWriteEnN != '1 |-> $past(writeStart, 2)
		|| $past(writeStart, 3) || $past(writeStart, 4) || $past(writeStart, 5))
		else $error("lane enable outside write data slots");
	// outside the four data slots of a write the host keeps data and enables idle
	a_write_quiet: assert property (!($past(writeStart, 2) || $past(writeStart, 3)
		|| $past(writeStart, 4) || $past(writeStart, 5))
		|-> ((wrData == '0) && (laneWriteEnN == '1)))
		else $error("write data moves outside its slots");
	// the shared address moves only together with a select
	a_addr_with_select: assert property (!$stable(addr)
		|-> (!readPortSelectN || !writePortSelectN))
		else $error("address changed without a request");
	// the first edge after reset still sees the reset phase
	a_phase_toggle: assert property (!$past(sys_rst) |-> kClk != $past(kClk))
		else $error("clock phase marker did not alternate");
endmodule
`default_nettype wire

// ### tb/burst4_split_port_sram_access_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "bspsa_cfg.svh"
module burst4_split_port_sram_access_tb_top;
	localparam int AW = 4; // small address keeps the arrays small
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmdValid = 1'b0;
	logic cmdReady;
	logic cmdWrite = 1'b0;
	logic [AW-1:0] cmdAddr = 4'h0;
	logic [71:0] cmdData = 72'h0;
	logic [7:0] cmdLaneEn = 8'h00;
	logic rspValid;
	logic rspReady = 1'b1;
	logic [71:0] rspData;
	// status levels of the device on the main link
	logic devReadActive;
	logic devWriteActive;
	int num_errors = 0;
	int comparisons = 0;
	int oeCycles = 0; // link cycles with read data driven
	int n;
	logic [71:0] shadow [16]; // expected array contents
	logic [71:0] expQ [$]; // read results still owed
	// one ordinary command: kind, address, data, lane enables
	typedef struct packed {logic w; logic [3:0] a; logic [71:0] d; logic [7:0] le;} bspsa_row_t;
	// second write to one place lands partly, so lanes are seen
	bspsa_row_t rows [8] = '{'{1'b1, 4'h3, 72'h0123456789abcdef01, 8'hff},
		'{1'b0, 4'h3, 72'h0, 8'h00}, '{1'b1, 4'h5, 72'hfedcba98765432100f, 8'hff},
		'{1'b1, 4'h5, 72'h3ffffffffffffffffa, 8'h96}, '{1'b0, 4'h5, 72'h0, 8'h00},
		'{1'b0, 4'h3, 72'h0, 8'h00}, '{1'b1, 4'hf, 72'h2aaaa5555aaaa55550, 8'hff},
		'{1'b0, 4'hf, 72'h0, 8'h00}};
	bspsa_link_if #(.ADDR_W(AW)) link();
	bspsa_link_if #(.ADDR_W(AW)) linkB(); // driven by the bench, breaks spacing
	bspsa_host_ctrl #(.ADDR_W(AW), .BUF_DEPTH(`BSPSA_BUF_DEPTH)) i_bspsa_host_ctrl(
		.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link.host), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
		.cmdLaneEn(cmdLaneEn), .rspValid(rspValid), .rspReady(rspReady), .rspData(rspData));
	bspsa_sram_dev #(.ADDR_W(AW)) i_bspsa_sram_dev(.sys_clk(sys_clk), .sys_rst(sys_rst),
		.link(link.dev), .readActive(devReadActive), .writeActive(devWriteActive));
	bspsa_sram_dev #(.ADDR_W(AW)) i_bspsa_sram_dev_b(.sys_clk(sys_clk), .sys_rst(sys_rst),
		.link(linkB.dev), .readActive(), .writeActive());
	bspsa_link_checker #(.ADDR_W(AW)) i_bspsa_link_checker(.sys_clk(sys_clk),
		.sys_rst(sys_rst), .kClk(link.kClk), .addr(link.addr),
		.readPortSelectN(link.readPortSelectN), .writePortSelectN(link.writePortSelectN),
		.wrData(link.wrData), .laneWriteEnN(link.laneWriteEnN), .rdData(link.rdData),
		.rdOe(link.rdOe));
	// clock and the phase marker of the second link
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		linkB.kClk <= sys_rst ? 1'b0 : ~linkB.kClk;
	end
	// one compare for every value; counts it
	task automatic checkVal(input string what, input logic [71:0] exp, input logic [71:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// holds the command until taken; valid stays up for the next one
	task automatic sendCmd(input logic w, input logic [AW-1:0] a, input logic [71:0] d,
		input logic [7:0] le);
		int t;
		t = 0;
		cmdValid <= 1'b1;
		cmdWrite <= w;
		cmdAddr <= a;
		cmdData <= d;
		cmdLaneEn <= le;
		do begin
			@(negedge sys_clk);
			t++;
		end while (cmdReady !== 1'b1 && t < 64);
		checkVal("command taken", 1, cmdReady);
		@(posedge sys_clk);
	endtask
	// counts driven cycles and checks each popped burst
	always @(posedge sys_clk) begin
		if (link.rdOe === 1'b1) oeCycles++;
		if (rspValid === 1'b1 && rspReady === 1'b1) begin
			if (expQ.size() == 0) checkVal("spurious response", 1, 0);
			else checkVal("read burst", expQ.pop_front(), rspData);
		end
	end
	// hang guard: the whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge sys_clk);
		num_errors++;
		$display("CHECK FAILED watchdog expected done seen hang");
		tally_and_finish();
	end
	initial begin
		// second link idle; its phase marker has its own process
		linkB.addr <= 4'h0;
		linkB.readPortSelectN <= 1'b1;
		linkB.writePortSelectN <= 1'b1;
		linkB.wrData <= 18'h0;
		linkB.laneWriteEnN <= 2'h3;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			sendCmd(rows[i].w, rows[i].a, rows[i].d, rows[i].le);
			if (rows[i].w) begin
				for (int l = 0; l < 8; l++) begin
					if (rows[i].le[l]) shadow[rows[i].a][9*l +: 9] = rows[i].d[9*l +: 9];
				end
			end else begin
				expQ.push_back(shadow[rows[i].a]);
			end
		end
		cmdValid <= 1'b0;
		repeat (20) @(posedge sys_clk);
		checkVal("responses owed", 0, expQ.size());
		checkVal("driven read cycles", 16, oeCycles);
		$display("test table done");
		// receiver stalls: two reads fill the buffer, a third must wait
		rspReady <= 1'b0;
		sendCmd(1'b0, 4'h3, 72'h0, 8'h00);
		expQ.push_back(shadow[3]);
		sendCmd(1'b0, 4'h5, 72'h0, 8'h00);
		expQ.push_back(shadow[5]);
		cmdAddr <= 4'hf;
		n = 0;
		repeat (24) begin
			@(negedge sys_clk);
			n += (cmdReady !== 1'b0);
		end
		checkVal("ready while buffer full", 0, n);
		checkVal("response held", 1, rspValid);
		@(posedge sys_clk);
		rspReady <= 1'b1;
		sendCmd(1'b0, 4'hf, 72'h0, 8'h00);
		expQ.push_back(shadow[15]);
		cmdValid <= 1'b0;
		repeat (20) @(posedge sys_clk);
		checkVal("responses after stall", 0, expQ.size());
		$display("test stall done");
		// both selects from idle, then a read on the very next rise
		do @(posedge sys_clk); while (linkB.kClk !== 1'b0);
		linkB.readPortSelectN <= 1'b0;
		linkB.writePortSelectN <= 1'b0;
		@(posedge sys_clk);
		linkB.readPortSelectN <= 1'b1;
		linkB.writePortSelectN <= 1'b1;
		@(posedge sys_clk);
		linkB.readPortSelectN <= 1'b0;
		@(posedge sys_clk);
		linkB.readPortSelectN <= 1'b1;
		n = 0;
		repeat (16) begin
			@(negedge sys_clk);
			n += (linkB.rdOe === 1'b1);
		end
		checkVal("cycles of one burst", 4, n);
		$display("test repeated read done");
		// reset in mid-run cuts a read burst and returns the link to idle
		@(posedge sys_clk);
		sendCmd(1'b0, 4'h3, 72'h0, 8'h00);
		cmdValid <= 1'b0;
		repeat (7) @(posedge sys_clk);
		@(negedge sys_clk);
		checkVal("burst under way", 1, link.rdOe);
		checkVal("read active", 1, devReadActive);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		@(negedge sys_clk);
		checkVal("read select idle", 1, link.readPortSelectN);
		checkVal("read outputs off", 0, link.rdOe);
		checkVal("read data cleared", 0, link.rdData);
		checkVal("read not active", 0, devReadActive);
		checkVal("no response", 0, rspValid);
		// two edges of reset, so the phase checks see it sampled
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// first command at the first edge after release: a write, then its read
		sendCmd(1'b1, 4'h6, 72'h123456789abcdef012, 8'hff);
		shadow[6] = 72'h123456789abcdef012;
		repeat (2) @(negedge sys_clk);
		checkVal("write active", 1, devWriteActive);
		@(posedge sys_clk);
		sendCmd(1'b0, 4'h6, 72'h0, 8'h00);
		expQ.push_back(shadow[6]);
		cmdValid <= 1'b0;
		repeat (20) @(posedge sys_clk);
		checkVal("responses after reset", 0, expQ.size());
		$display("test reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
